// ===== core/gpa_pin_cell.sv
// decode of direction, attribute and data into pad controls
`timescale 1ns/100ps
module gpa_pin_cell #(
   parameter bit OPEN_DRAIN = 1'b0
) (
   // configuration bits
   input wire logic dir_i,
   input wire logic att_i,
   input wire logic dat_i,
   // pad controls
   output logic out_o,
   output logic oe_o,
   output logic pu_o,
   output logic pd_o
);

   // output drive: open drain pin only ever pulls low
   always_comb
   begin
      if (OPEN_DRAIN)
      begin
         out_o = 1'b0;
         oe_o = dir_i & (dat_i ~^ att_i);
      end
      else
      begin
         out_o = dat_i ^ att_i; // [R5]
         oe_o = dir_i;
      end
   end

   // input pulls: data 0 floats, data 1 picks pull by attribute
   assign pd_o = ~dir_i & dat_i & ~att_i;
   assign pu_o = ~dir_i & dat_i & att_i;

endmodule

// ===== core/gpa_pkg.sv
// constants shared by the port A pin logic
package gpa_pkg;

   // ----------------------------------------
   // register indexes, byte address is index times four
   // ----------------------------------------
   localparam int unsigned IDX_W = 7;
   localparam int unsigned ADR_LSB = 2;
   localparam logic [IDX_W-1:0] IDX_ATT = 7'h03;
   localparam logic [IDX_W-1:0] IDX_DAT = 7'h07;
   localparam logic [IDX_W-1:0] IDX_DIR = 7'h0b;
   localparam logic [IDX_W-1:0] IDX_DBF = 7'h0c;
   localparam logic [IDX_W-1:0] IDX_SEL = 7'h4a;
   localparam logic [IDX_W-1:0] IDX_AUX = 7'h50;

   // ----------------------------------------
   // widths and reset values
   // ----------------------------------------
   localparam int unsigned PORT_W = 8;
   localparam int unsigned KEY_W = 19;
   // edges before synchronised key levels and their copy are both valid
   localparam int unsigned KEY_PRIME_W = 3;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic RST_IR_GPIO = 1'b0;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

   // ----------------------------------------
   // fields of the auxiliary pin register
   // ----------------------------------------
   localparam int unsigned AUX_DIR_BIT = 0;
   localparam int unsigned AUX_ATT_BIT = 1;
   localparam int unsigned AUX_DAT_BIT = 2;
   localparam int unsigned AUX_IR_GPIO_BIT = 3;
   localparam int unsigned AUX_LEVEL_BIT = 4;

endpackage

// ===== core/gpa_port.sv
// port A pin controller with segment routing and wishbone registers
//
// Functional notes
// R1: after reset all pins are plain inputs while the infrared pin runs its transmit function.
// R2: a direction bit of 0 makes its pin an input and 1 makes it an output.
// R3: an input pin with data 0 floats, and with data 1 and attribute 0 it pulls low.
// R4: an input pin with data 1 and attribute 1 pulls high.
// R5: an output pin drives its data bit, inverted when the attribute bit is 1.
// R6: the open drain pin never drives high and pulls low only when data equals attribute.
// R7: reading the data register returns the live pin levels.
// R8: reading the data buffer returns the value last written to the data register.
// R9: writing the data register sets output levels and input pulls together with direction and attribute.
// R10: each segment select bit routes its pin to GPIO at 0 or to the segment driver at 1, reset 0.
// R11: pins 7 to 0 carry segment outputs 23 to 16 when selected.
// R12: in sleep, a level change on a keyboard pin set as input raises a wakeup.
// R13: a pin routed to its segment is driven by the segment driver and GPIO drive is cut off.
// R14: pin levels pass a two stage synchroniser before a read returns them.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/100ps
module gpa_port #(
   parameter int unsigned KEY_W = gpa_pkg::KEY_W
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [8:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // port A pads and segment driver levels 23 to 16
   input wire logic [7:0] pad_i,
   output logic [7:0] pad_o,
   output logic [7:0] pad_oe_o,
   output logic [7:0] pad_pu_o,
   output logic [7:0] pad_pd_o,
   input wire logic [7:0] seg_i,
   // open drain special pin
   input wire logic od_pad_i,
   output logic od_pad_o,
   output logic od_pad_oe_o,
   output logic od_pad_pu_o,
   output logic od_pad_pd_o,
   // infrared transmit pin
   input wire logic ir_tx_i,
   output logic ir_pad_o,
   output logic ir_pad_oe_o,
   // keyboard wakeup
   input wire logic sleep_i,
   input wire logic [KEY_W-1:0] key_pad_i,
   input wire logic [KEY_W-1:0] key_is_input_i,
   output logic wakeup_o
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] att;
      logic [7:0] dat;
      logic [7:0] dir;
      logic [7:0] sel;
      logic od_dir;
      logic od_att;
      logic od_dat;
      logic ir_gpio;
      logic ack;
      logic [31:0] rdat;
      logic [7:0] pad;
      logic [7:0] oe;
      logic [7:0] pu;
      logic [7:0] pd;
      logic od_out;
      logic od_oe;
      logic od_pu;
      logic od_pd;
      logic ir_out;
      logic ir_oe;
      logic [KEY_W-1:0] key_prev;
      logic [gpa_pkg::KEY_PRIME_W-1:0] key_primed;
      logic wake;
   } gpa_state_s;

   gpa_state_s st_q;
   gpa_state_s st_d;

   logic [7:0] pad_s;
   logic od_s;
   logic [KEY_W-1:0] key_s;
   logic [7:0] c_out;
   logic [7:0] c_oe;
   logic [7:0] c_pu;
   logic [7:0] c_pd;
   logic od_out;
   logic od_oe;
   logic od_pu;
   logic od_pd;
   logic req;
   logic [gpa_pkg::IDX_W-1:0] idx;

   // true when the request addresses the given register
   function automatic logic reg_hit(input logic [gpa_pkg::IDX_W-1:0] a,
                                    input logic [gpa_pkg::IDX_W-1:0] r);
      reg_hit = (a == r);
   endfunction

   // ----------------------------------------
   // synchronisers and pin decode
   // ----------------------------------------

   // pad levels reach the bus only through two synchroniser flops and then the read data flop
   gpa_sync #(.W(gpa_pkg::PORT_W)) u_pad_sync ( // [R14]
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(pad_i),
      .q_o(pad_s)
   );

   gpa_sync #(.W(1)) u_od_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(od_pad_i),
      .q_o(od_s)
   );

   gpa_sync #(.W(KEY_W)) u_key_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(key_pad_i),
      .q_o(key_s)
   );

   // standard cells for port A
   for (genvar g = 0; g < gpa_pkg::PORT_W; g++)
   begin : g_cell
      gpa_pin_cell #(.OPEN_DRAIN(1'b0)) u_cell (
         .dir_i(st_q.dir[g]),
         .att_i(st_q.att[g]),
         .dat_i(st_q.dat[g]),
         .out_o(c_out[g]),
         .oe_o(c_oe[g]),
         .pu_o(c_pu[g]),
         .pd_o(c_pd[g])
      );
   end

   // open drain special pin
   gpa_pin_cell #(.OPEN_DRAIN(1'b1)) u_od_cell ( // [R6]
      .dir_i(st_q.od_dir),
      .att_i(st_q.od_att),
      .dat_i(st_q.od_dat),
      .out_o(od_out),
      .oe_o(od_oe),
      .pu_o(od_pu),
      .pd_o(od_pd)
   );

   assign req = wb_cyc_i & wb_stb_i;
   assign idx = wb_adr_i[8:gpa_pkg::ADR_LSB];

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      st_d = st_q;
      // one cycle answer, ack dropped after each beat
      st_d.ack = req & ~st_q.ack;
      // read data captured in the request cycle
      st_d.rdat = gpa_pkg::RD_ZERO;
      if (reg_hit(idx, gpa_pkg::IDX_ATT))
         st_d.rdat[7:0] = st_q.att;
      if (reg_hit(idx, gpa_pkg::IDX_DAT))
         st_d.rdat[7:0] = pad_s; // [R7]
      if (reg_hit(idx, gpa_pkg::IDX_DIR))
         st_d.rdat[7:0] = st_q.dir;
      if (reg_hit(idx, gpa_pkg::IDX_DBF))
         st_d.rdat[7:0] = st_q.dat; // [R8]
      if (reg_hit(idx, gpa_pkg::IDX_SEL))
         st_d.rdat[7:0] = st_q.sel;
      if (reg_hit(idx, gpa_pkg::IDX_AUX))
      begin
         st_d.rdat[gpa_pkg::AUX_DIR_BIT] = st_q.od_dir;
         st_d.rdat[gpa_pkg::AUX_ATT_BIT] = st_q.od_att;
         st_d.rdat[gpa_pkg::AUX_DAT_BIT] = st_q.od_dat;
         st_d.rdat[gpa_pkg::AUX_IR_GPIO_BIT] = st_q.ir_gpio;
         st_d.rdat[gpa_pkg::AUX_LEVEL_BIT] = od_s;
      end
      // writes commit on the edge where the master sees ack
      if (req & st_q.ack & wb_we_i & wb_sel_i[0])
      begin
         if (reg_hit(idx, gpa_pkg::IDX_ATT))
            st_d.att = wb_dat_i[7:0];
         if (reg_hit(idx, gpa_pkg::IDX_DAT))
            st_d.dat = wb_dat_i[7:0]; // [R9]
         if (reg_hit(idx, gpa_pkg::IDX_DIR))
            st_d.dir = wb_dat_i[7:0]; // [R2]
         if (reg_hit(idx, gpa_pkg::IDX_SEL))
            st_d.sel = wb_dat_i[7:0]; // [R10]
         if (reg_hit(idx, gpa_pkg::IDX_AUX))
         begin
            st_d.od_dir = wb_dat_i[gpa_pkg::AUX_DIR_BIT];
            st_d.od_att = wb_dat_i[gpa_pkg::AUX_ATT_BIT];
            st_d.od_dat = wb_dat_i[gpa_pkg::AUX_DAT_BIT];
            st_d.ir_gpio = wb_dat_i[gpa_pkg::AUX_IR_GPIO_BIT];
         end
      end
      // segment driver owns selected pins, gpio drive and pulls cut off
      st_d.pad = (st_q.sel & seg_i) | (~st_q.sel & c_out); // [R11] [R13]
      st_d.oe = st_q.sel | c_oe; // [R2] [R5]
      st_d.pu = ~st_q.sel & c_pu; // [R4]
      st_d.pd = ~st_q.sel & c_pd; // [R3]
      st_d.od_out = od_out;
      st_d.od_oe = od_oe;
      st_d.od_pu = od_pu;
      st_d.od_pd = od_pd;
      // infrared pin sends the transmitter unless released to input
      st_d.ir_out = ir_tx_i & ~st_q.ir_gpio;
      st_d.ir_oe = ~st_q.ir_gpio; // [R1]
      // keyboard change detect, armed only once the flushed synchronisers and their copy agree,
      // so pins idling high give no false wakeup after reset
      st_d.key_prev = key_s;
      st_d.key_primed = {st_q.key_primed[gpa_pkg::KEY_PRIME_W-2:0], 1'b1};
      st_d.wake = sleep_i & st_q.key_primed[gpa_pkg::KEY_PRIME_W-1]
                  & (|((key_s ^ st_q.key_prev) & key_is_input_i)); // [R12]
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_q <= '0; // [R1]
         st_q.att <= gpa_pkg::RST_BYTE;
         st_q.dat <= gpa_pkg::RST_BYTE;
         st_q.dir <= gpa_pkg::RST_BYTE;
         st_q.sel <= gpa_pkg::RST_BYTE; // [R10]
         st_q.ir_gpio <= gpa_pkg::RST_IR_GPIO;
         st_q.ir_oe <= ~gpa_pkg::RST_IR_GPIO; // [R1]
      end
      else
         st_q <= st_d;
   end

   // outputs straight from flops
   assign wb_ack_o = st_q.ack;
   assign wb_dat_o = st_q.rdat;
   assign pad_o = st_q.pad;
   assign pad_oe_o = st_q.oe;
   assign pad_pu_o = st_q.pu;
   assign pad_pd_o = st_q.pd;
   assign od_pad_o = st_q.od_out;
   assign od_pad_oe_o = st_q.od_oe;
   assign od_pad_pu_o = st_q.od_pu;
   assign od_pad_pd_o = st_q.od_pd;
   assign ir_pad_o = st_q.ir_out;
   assign ir_pad_oe_o = st_q.ir_oe;
   assign wakeup_o = st_q.wake;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   after_reset_a: assert property ($past(rst_i) |-> pad_oe_o == 8'h00 && ir_pad_oe_o && !od_pad_oe_o) // [R1]
      else $error("pins not inputs after reset");
   dir_drive_a: assert property (!$past(rst_i) |-> pad_oe_o == $past(st_q.dir | st_q.sel)) // [R2]
      else $error("output enable does not follow direction");
   pull_low_a: assert property (!$past(rst_i) |-> pad_pd_o == $past(~st_q.dir & ~st_q.att & st_q.dat & ~st_q.sel)) // [R3]
      else $error("pull low wrong");
   pull_high_a: assert property (!$past(rst_i) |-> pad_pu_o == $past(~st_q.dir & st_q.att & st_q.dat & ~st_q.sel)) // [R4]
      else $error("pull high wrong");
   drive_level_a: assert property (!$past(rst_i) |->
      ((pad_o ^ $past(st_q.dat ^ st_q.att)) & $past(st_q.dir & ~st_q.sel)) == 8'h00) // [R5]
      else $error("driven level wrong");
   open_drain_a: assert property (!$past(rst_i) |->
      od_pad_oe_o == $past(st_q.od_dir & (st_q.od_dat ~^ st_q.od_att)) && !od_pad_o) // [R6]
      else $error("open drain pin misdriven");
   read_pins_a: assert property (wb_ack_o && !$past(rst_i) && $past(!wb_we_i && idx == gpa_pkg::IDX_DAT) |->
      wb_dat_o[7:0] == $past(pad_s)) // [R7]
      else $error("data read not pin level");
   read_buffer_a: assert property (wb_ack_o && !$past(rst_i) && $past(!wb_we_i && idx == gpa_pkg::IDX_DBF) |->
      wb_dat_o[7:0] == $past(st_q.dat)) // [R8]
      else $error("buffer read not stored data");
   write_data_a: assert property (wb_ack_o && req && wb_we_i && wb_sel_i[0] && idx == gpa_pkg::IDX_DAT |=>
      st_q.dat == $past(wb_dat_i[7:0])) // [R9]
      else $error("data write lost");
   segment_route_a: assert property (!$past(rst_i) |->
      ((pad_o ^ $past(seg_i)) & $past(st_q.sel)) == 8'h00 && (pad_pu_o & $past(st_q.sel)) == 8'h00) // [R10] [R11] [R13]
      else $error("segment routing wrong");
   key_wake_a: assert property (!$past(rst_i) && $past(sleep_i && st_q.key_primed[gpa_pkg::KEY_PRIME_W-1])
      && $past((key_s ^ st_q.key_prev) & key_is_input_i) != '0 |-> wakeup_o) // [R12]
      else $error("keyboard change missed");
   pad_sync_a: assert property (!$past(rst_i) && !$past(rst_i, 2) |-> pad_s == $past(pad_i, 2)) // [R14]
      else $error("pad synchroniser depth wrong");

   wr_seen_c: cover property (wb_ack_o && wb_we_i && idx == gpa_pkg::IDX_DAT);
   rd_seen_c: cover property (wb_ack_o && !wb_we_i && idx == gpa_pkg::IDX_DAT);
   seg_seen_c: cover property (st_q.sel != 8'h00);
   wake_seen_c: cover property (wakeup_o);

endmodule

// ===== core/gpa_sync.sv
// two stage level synchroniser
`timescale 1ns/100ps
module gpa_sync #(
   parameter int unsigned W = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // levels
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } gpa_sync_s;

   gpa_sync_s st_q;
   gpa_sync_s st_d;

   // first stage feeds only the second stage
   always_comb
   begin
      st_d.s1 = d_i;
      st_d.s2 = st_q.s1;
   end

   // state register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign q_o = st_q.s2;

endmodule

// ===== test/gpa_port_tb.sv
// self-checking bench for the port A pin controller
`timescale 1ns/100ps
module testbench;
   // ------
   // signals
   // ------
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [8:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [7:0] pad_i, pad_o, pad_oe_o, pad_pu_o, pad_pd_o, seg_i;
   logic od_pad_i, od_pad_o, od_pad_oe_o, od_pad_pu_o, od_pad_pd_o;
   logic ir_tx_i, ir_pad_o, ir_pad_oe_o, sleep_i, wakeup_o;
   logic [gpa_pkg::KEY_W-1:0] key_pad_i, key_is_input_i;
   logic [7:0] m_att, m_dir, m_dat, m_sel, rnd;
   logic [31:0] exp_q[$];
   string nm_q[$];
   int checks, n_mismatch;

   gpa_port gpa_port_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pad_i(pad_i), .pad_o(pad_o), .pad_oe_o(pad_oe_o),
      .pad_pu_o(pad_pu_o), .pad_pd_o(pad_pd_o), .seg_i(seg_i), .od_pad_i(od_pad_i), .od_pad_o(od_pad_o),
      .od_pad_oe_o(od_pad_oe_o), .od_pad_pu_o(od_pad_pu_o), .od_pad_pd_o(od_pad_pd_o),
      .ir_tx_i(ir_tx_i), .ir_pad_o(ir_pad_o), .ir_pad_oe_o(ir_pad_oe_o), .sleep_i(sleep_i),
      .key_pad_i(key_pad_i), .key_is_input_i(key_is_input_i), .wakeup_o(wakeup_o));

   // free running 100 MHz clock
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // ------
   // helpers
   // ------
   function automatic logic [7:0] nx();
      rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
      return rnd;
   endfunction

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
      checks++;
      if (seen !== e)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, seen);
      end
   endtask

   task automatic summarize();
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // one classic wishbone cycle, held until ack is sampled high
   task automatic wb_xfer(input logic we, input logic [6:0] idx, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= s;
      wb_dat_i <= d;
      // ack is sampled at the rising edge, where the write commits and read data is taken
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1)
      begin
         check("wb_ack", wb_ack_o, 32'h1);
         summarize();
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk_i);
   endtask

   // read with the expected value noted for the watcher
   task automatic rd(input logic [6:0] idx, input logic [31:0] e, input string nm);
      exp_q.push_back(e);
      nm_q.push_back(nm);
      wb_xfer(1'b0, idx, 32'h0, 4'hf);
   endtask

   // read data is compared in the ack cycle
   always @(posedge clk_i)
   begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      begin
         if (exp_q.size() == 0)
            check("unexpected_read", 32'h1, 32'h0);
         else
            check(nm_q.pop_front(), wb_dat_o, exp_q.pop_front());
      end
   end

   // pad controls against the decode of the model registers
   task automatic chk_pads();
      logic [7:0] eoe, eout;
      eoe = m_dir | m_sel;
      eout = (m_sel & seg_i) | (~m_sel & (m_dat ^ m_att));
      @(negedge clk_i);
      check("pad_oe", pad_oe_o, eoe);
      check("pad_out", pad_o & eoe, eout & eoe);
      check("pad_pu", pad_pu_o, ~m_sel & ~m_dir & m_dat & m_att);
      check("pad_pd", pad_pd_o, ~m_sel & ~m_dir & m_dat & ~m_att);
   endtask

   task automatic set_port(input logic [7:0] a, input logic [7:0] d, input logic [7:0] t, input logic [7:0] s);
      m_att = a;
      m_dir = d;
      m_dat = t;
      m_sel = s;
      @(posedge clk_i);
      seg_i <= nx();
      pad_i <= nx();
      wb_xfer(1'b1, gpa_pkg::IDX_ATT, {24'h0, a}, 4'hf);
      wb_xfer(1'b1, gpa_pkg::IDX_DIR, {24'h0, d}, 4'hf);
      wb_xfer(1'b1, gpa_pkg::IDX_DAT, {24'h0, t}, 4'hf);
      wb_xfer(1'b1, gpa_pkg::IDX_SEL, {24'h0, s}, 4'hf);
      chk_pads();
      rd(gpa_pkg::IDX_DBF, {24'h0, t}, "data_buffer");
      rd(gpa_pkg::IDX_DAT, {24'h0, pad_i}, "data_live");
      rd(gpa_pkg::IDX_SEL, {24'h0, s}, "segment_select");
   endtask

   task automatic reset_and_defaults();
      logic seen;
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      {m_att, m_dir, m_dat, m_sel} = 32'h0;
      @(negedge clk_i);
      check("pad_oe", pad_oe_o | pad_pu_o | pad_pd_o, 32'h0);
      check("od_oe", od_pad_oe_o, 32'h0);
      check("ir_oe", ir_pad_oe_o, 32'h1);
      // no false wakeup while the key synchronisers refill
      seen = 1'b0;
      repeat (6)
      begin
         @(negedge clk_i);
         seen = seen | wakeup_o;
      end
      check("wake_after_reset", seen, 32'h0);
      rd(gpa_pkg::IDX_ATT, 32'h0, "attribute");
      rd(gpa_pkg::IDX_DIR, 32'h0, "direction");
      rd(gpa_pkg::IDX_DBF, 32'h0, "data_buffer");
      rd(gpa_pkg::IDX_SEL, 32'h0, "segment_select");
      rd(gpa_pkg::IDX_DAT, {24'h0, pad_i}, "data_live");
      rd(7'h10, 32'h0, "unmapped");
   endtask

   task automatic wake_chk(input int b, input logic e);
      logic seen;
      seen = 1'b0;
      @(posedge clk_i);
      key_pad_i[b] <= ~key_pad_i[b];
      repeat (8)
      begin
         @(negedge clk_i);
         if (wakeup_o !== 1'b0)
            seen = 1'b1;
      end
      check("wakeup", seen, e);
   endtask

   // ------
   // main sequence
   // ------
   initial
   begin
      int i;
      checks = 0;
      n_mismatch = 0;
      rnd = 8'h1d;
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {1'b1, 48'h0};
      {pad_i, seg_i, od_pad_i, ir_tx_i, sleep_i} = 19'h0;
      key_pad_i = '0;
      key_is_input_i = '1;
      reset_and_defaults();
      // every row of the decode table, one row per pin
      set_port(8'hf0, 8'hcc, 8'haa, 8'h00);
      set_port(8'h0f, 8'hf0, 8'h0f, 8'h5a);
      repeat (6) set_port(nx(), nx(), nx(), nx());
      // refused writes: byte lane off and read-only buffer
      wb_xfer(1'b1, gpa_pkg::IDX_ATT, 32'hff, 4'he);
      wb_xfer(1'b1, gpa_pkg::IDX_DBF, {24'h0, ~m_dat}, 4'hf);
      rd(gpa_pkg::IDX_ATT, {24'h0, m_att}, "attribute");
      rd(gpa_pkg::IDX_DBF, {24'h0, m_dat}, "data_buffer");
      // open drain pin over all eight settings, infrared pin follows its source
      for (i = 0; i < 8; i++)
      begin
         @(posedge clk_i);
         ir_tx_i <= i[0];
         od_pad_i <= i[1];
         wb_xfer(1'b1, gpa_pkg::IDX_AUX, {29'h0, i[2:0]}, 4'hf);
         @(negedge clk_i);
         check("od_oe", od_pad_oe_o, i[0] & (i[2] == i[1]));
         check("od_out", od_pad_o, 32'h0);
         check("od_pu", od_pad_pu_o, ~i[0] & i[2] & i[1]);
         check("od_pd", od_pad_pd_o, ~i[0] & i[2] & ~i[1]);
         check("ir_out", {ir_pad_oe_o, ir_pad_o}, {1'b1, i[0]});
         rd(gpa_pkg::IDX_AUX, {27'h0, i[1], 1'b0, i[2:0]}, "aux");
      end
      wb_xfer(1'b1, gpa_pkg::IDX_AUX, 32'h8, 4'hf);
      @(negedge clk_i);
      check("ir_oe", ir_pad_oe_o, 32'h0);
      // keyboard wakeup only in sleep, only from input pins
      wake_chk(5, 1'b0);
      @(posedge clk_i);
      sleep_i <= 1'b1;
      key_is_input_i <= ~19'h1;
      wake_chk(0, 1'b0);
      wake_chk(5, 1'b1);
      reset_and_defaults();
      repeat (4) @(posedge clk_i);
      check("reads_left", exp_q.size(), 32'h0);
      summarize();
   end
endmodule
